// ---- pkg/strap_cfg.svh ----
`ifndef STRAP_LATCH_CFG_SVH
`define STRAP_LATCH_CFG_SVH

// Decoded five-level resistor codes.
`define LVL_WEAK_PD      3'h0
`define LVL_WEAK_PU      3'h1
`define LVL_MED_PD       3'h2
`define LVL_MED_PU       3'h3
`define LVL_STRONG_PD    3'h4

// Port-count masks, bit 0 is port 1.
`define MASK_NONE        4'h0
`define MASK_P1          4'h1
`define MASK_P12         4'h3
`define MASK_P123        4'h7
`define MASK_P1234       4'hf

// Function-set codes (set 1..4 as 0..3).
`define FSET_I2C         2'h0
`define FSET_I2S         2'h1
`define FSET_UART        2'h2
`define FSET_GPIO        2'h3

// Pin function codes.
`define FN_WIDTH         6
`define FN_RESERVED      6'h00
`define FN_CABLE_A       6'h01
`define FN_CABLE_B       6'h02
`define FN_GPIO68        6'h03
`define FN_DISCHARGE     6'h04
`define FN_GPIO70        6'h05
`define FN_GPIO71        6'h06
`define FN_PN_DATA       6'h07
`define FN_PN_CLOCK      6'h08
`define FN_BC_DATA       6'h09
`define FN_BC_CLOCK      6'h0a
`define FN_P3_SS_PWR     6'h0b
`define FN_P3_PWR        6'h0c
`define FN_GPIO78        6'h0d
`define FN_ALERT_B       6'h0e
`define FN_P4_PWR        6'h0f
`define FN_P1_PWR        6'h10
`define FN_ALERT_A       6'h11
`define FN_TGT_DATA      6'h12
`define FN_SPI_CE_N      6'h13
`define FN_SPI_CLK       6'h14
`define FN_SPI_D0        6'h15
`define FN_SPI_D1        6'h16
`define FN_SPI_D2        6'h17
`define FN_SPI_D3        6'h18
`define FN_TGT_CLOCK     6'h19
`define FN_GPIO91        6'h1a
`define FN_GPIO92        6'h1b
`define FN_GPIO93        6'h1c
`define FN_GPIO94        6'h1d
`define FN_GPIO95        6'h1e
`define FN_MICROPHONE_PLUG_DETECT       6'h1f
`define FN_I2S_SDI       6'h20
`define FN_I2S_SDO       6'h21
`define FN_I2S_SCK       6'h22
`define FN_I2S_MCLK      6'h23
`define FN_I2S_LRCK      6'h24
`define FN_UART_RX       6'h25
`define FN_UART_TX       6'h26
`define FN_UART_CTS_N    6'h27
`define FN_UART_RTS_N    6'h28
`define FN_UART_DSR_N    6'h29
`define FN_UART_DTR_N    6'h2a
`define FN_UART_DCD_N    6'h2b
`define FN_GPIO83        6'h2c
`define FN_GPIO90        6'h2d

`define PIN_LO           2
`define PIN_HI           31

`endif

// ---- pkg/strap_pkg.sv ----
package strap_pkg;
    typedef enum logic [1:0] {
        ST_RESET,
        ST_CAPTURE,
        ST_HELD
    } latch_state_t;
endpackage

// ---- logic/level_to_mask.sv ----
`timescale 1ns/100ps
`include "strap_cfg.svh"

// Turns a five-level strap code into a port mask; reserved codes give no ports.
module level_to_mask (
    // Decoded strap level
    input  wire logic [2:0] level_in,
    // Port mask and validity
    output logic      [3:0] mask_out,
    output logic            valid_out
);
    assign valid_out = (level_in <= `LVL_STRONG_PD);
    assign mask_out  = (level_in == `LVL_WEAK_PU)   ? `MASK_P1    :
                       (level_in == `LVL_MED_PD)    ? `MASK_P12   :
                       (level_in == `LVL_MED_PU)    ? `MASK_P123  :
                       (level_in == `LVL_STRONG_PD) ? `MASK_P1234 : `MASK_NONE;
endmodule

// ---- logic/strap_latch_pin_function_select.sv ----
`timescale 1ns/100ps
`include "strap_cfg.svh"

module strap_latch_pin_function_select
    import strap_pkg::*;
#(
    parameter int PORTS = 4,
    parameter int PINS  = 30
) (
    // Clock and reset
    input  wire logic                          clk_in,
    input  wire logic                          srst_in,
    // Strap inputs
    input  wire logic [PORTS-1:0]              port_pos_line_disable_strap_in,
    input  wire logic [PORTS-1:0]              port_neg_line_disable_strap_in,
    input  wire logic [2:0]                    fixed_port_count_strap_in,
    input  wire logic [2:0]                    charging_port_count_strap_in,
    input  wire logic [2:0]                    function_set_lo_strap_in,
    input  wire logic [2:0]                    function_set_hi_strap_in,
    input  wire logic [2:0]                    function_set_unused_strap_in,
    // Pin mux override
    input  wire logic [PINS-1:0]               pin_override_en_in,
    input  wire logic [PINS*`FN_WIDTH-1:0]     pin_override_fn_in,
    // Port configuration
    output logic      [PORTS-1:0]              pos_line_disabled_out,
    output logic      [PORTS-1:0]              neg_line_disabled_out,
    output logic      [PORTS-1:0]              port_disabled_out,
    output logic      [PORTS-1:0]              superspeed_disabled_out,
    output logic      [PORTS-1:0]              fixed_port_out,
    output logic      [PORTS-1:0]              charging_port_out,
    output logic                               strap_reserved_out,
    output logic                               straps_valid_out,
    // Pin functions
    output logic      [1:0]                    function_set_out,
    output logic      [PINS*`FN_WIDTH-1:0]     programmable_function_pin_fn_out
);

    // The decode tables are written for four ports and the thirty pins from 2 to 31.
    if (PORTS != 4 || PINS != `PIN_HI - `PIN_LO + 1) begin : g_param_check
        $error("strap_latch_pin_function_select supports four ports and 30 pins only");
    end

    ////////////////////////////////////////////////////////////////////////////
    // Capture sequencing.

    latch_state_t state_q;
    latch_state_t state_d;
    logic         capture;

    always_comb begin
        state_d = state_q;
        case (state_q)
            ST_RESET:   state_d = ST_CAPTURE;
            ST_CAPTURE: state_d = ST_HELD;
            ST_HELD:    state_d = ST_HELD;
            default:    state_d = ST_RESET;
        endcase
    end

    assign capture = (state_q == ST_CAPTURE);

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            state_q <= ST_RESET;
        end else begin
            state_q <= state_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Strap holding registers.

    logic [PORTS-1:0] pos_q;
    logic [PORTS-1:0] neg_q;
    logic [2:0]       fixed_lvl_q;
    logic [2:0]       chg_lvl_q;
    logic [2:0]       set_lo_q;
    logic [2:0]       set_hi_q;
    logic             held_q;

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            pos_q       <= '0;
            neg_q       <= '0;
            fixed_lvl_q <= `LVL_WEAK_PD;
            chg_lvl_q   <= `LVL_WEAK_PD;
            set_lo_q    <= `LVL_WEAK_PD;
            set_hi_q    <= `LVL_WEAK_PD;
            held_q      <= 1'b0;
        end else if (capture) begin
            pos_q       <= port_pos_line_disable_strap_in;
            neg_q       <= port_neg_line_disable_strap_in;
            fixed_lvl_q <= fixed_port_count_strap_in;
            chg_lvl_q   <= charging_port_count_strap_in;
            set_lo_q    <= function_set_lo_strap_in;
            set_hi_q    <= function_set_hi_strap_in;
            held_q      <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Port configuration decode.

    logic fixed_ok;
    logic chg_ok;
    logic set_ok;

    assign pos_line_disabled_out = pos_q;
    assign neg_line_disabled_out = neg_q;
    assign port_disabled_out       = pos_q & neg_q;
    assign superspeed_disabled_out = pos_q & neg_q;
    assign straps_valid_out        = held_q;

    level_to_mask u_fixed (
        .level_in  (fixed_lvl_q),
        .mask_out  (fixed_port_out),
        .valid_out (fixed_ok)
    );

    level_to_mask u_charge (
        .level_in  (chg_lvl_q),
        .mask_out  (charging_port_out),
        .valid_out (chg_ok)
    );

    assign set_ok = (set_hi_q == `LVL_WEAK_PD) && (set_lo_q <= `LVL_MED_PU);
    assign function_set_out = set_lo_q[1:0];
    assign strap_reserved_out = held_q & ~(fixed_ok & chg_ok & set_ok);

    ////////////////////////////////////////////////////////////////////////////
    // Pin function tables, index 0 is pin 2.

    function automatic logic [`FN_WIDTH-1:0] default_fn(input int pin, input logic [1:0] fs);
        logic [`FN_WIDTH-1:0] f;
        f = `FN_RESERVED;
        case (pin)
            2:  f = `FN_CABLE_A;
            3:  f = `FN_CABLE_B;
            4:  f = `FN_GPIO68;
            5:  f = `FN_DISCHARGE;
            8:  f = `FN_PN_DATA;
            9:  f = `FN_PN_CLOCK;
            10: f = `FN_BC_DATA;
            11: f = `FN_BC_CLOCK;
            12: f = `FN_P3_SS_PWR;
            13: f = `FN_P3_PWR;
            15: f = `FN_ALERT_B;
            16: f = `FN_P4_PWR;
            17: f = `FN_P1_PWR;
            18: f = `FN_ALERT_A;
            20: f = `FN_SPI_CE_N;
            21: f = `FN_SPI_CLK;
            22: f = `FN_SPI_D0;
            23: f = `FN_SPI_D1;
            24: f = `FN_SPI_D2;
            25: f = `FN_SPI_D3;
            29: f = `FN_GPIO93;
            30: f = `FN_GPIO94;
            31: f = `FN_GPIO95;
            default: f = `FN_RESERVED;
        endcase
        case (fs)
            `FSET_I2S: begin
                case (pin)
                    6:  f = `FN_GPIO70;
                    7:  f = `FN_MICROPHONE_PLUG_DETECT;
                    14: f = `FN_I2S_SDI;
                    19: f = `FN_I2S_SDO;
                    26: f = `FN_I2S_SCK;
                    27: f = `FN_I2S_MCLK;
                    28: f = `FN_I2S_LRCK;
                    default: f = f;
                endcase
            end
            `FSET_UART: begin
                case (pin)
                    6:  f = `FN_UART_RX;
                    7:  f = `FN_UART_TX;
                    14: f = `FN_UART_CTS_N;
                    19: f = `FN_UART_RTS_N;
                    26: f = `FN_UART_DSR_N;
                    27: f = `FN_UART_DTR_N;
                    28: f = `FN_UART_DCD_N;
                    default: f = f;
                endcase
            end
            default: begin
                case (pin)
                    6:  f = `FN_GPIO70;
                    7:  f = `FN_GPIO71;
                    14: f = `FN_GPIO78;
                    19: f = (fs == `FSET_GPIO) ? `FN_GPIO83 : `FN_TGT_DATA;
                    26: f = (fs == `FSET_GPIO) ? `FN_GPIO90 : `FN_TGT_CLOCK;
                    27: f = `FN_GPIO91;
                    28: f = `FN_GPIO92;
                    default: f = f;
                endcase
            end
        endcase
        return f;
    endfunction

    logic [PINS*`FN_WIDTH-1:0] fn_d;
    logic [PINS*`FN_WIDTH-1:0] fn_q;

    for (genvar i = 0; i < PINS; i++) begin : g_pin
        assign fn_d[i*`FN_WIDTH +: `FN_WIDTH] = pin_override_en_in[i] ?
            pin_override_fn_in[i*`FN_WIDTH +: `FN_WIDTH] :
            default_fn(i + `PIN_LO, function_set_out);
    end

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            fn_q <= '0;
        end else if (held_q) begin
            fn_q <= fn_d;
        end
    end

    assign programmable_function_pin_fn_out = fn_q;

    ////////////////////////////////////////////////////////////////////////////
    // Assertions.

    sequence s_release;
        $fell(srst_in) ##1 !srst_in;
    endsequence

    a_capture_timing: assert property (
        @(posedge clk_in) disable iff (srst_in)
        s_release |=> held_q && pos_q == $past(port_pos_line_disable_strap_in))
        else $error("straps not captured one cycle after release");

    a_straps_hold: assert property (
        @(posedge clk_in) disable iff (srst_in)
        $past(held_q) |-> $stable(pos_q) && $stable(fixed_lvl_q) && $stable(set_lo_q))
        else $error("held straps changed without reset");

    a_pos_line_map: assert property (
        @(posedge clk_in) disable iff (srst_in)
        held_q |-> pos_line_disabled_out == pos_q)
        else $error("positive line disable wrong");

    a_neg_line_map: assert property (
        @(posedge clk_in) disable iff (srst_in)
        held_q |-> neg_line_disabled_out == neg_q)
        else $error("negative line disable wrong");

    a_port_both_lines: assert property (
        @(posedge clk_in) disable iff (srst_in)
        port_disabled_out == (pos_line_disabled_out & neg_line_disabled_out))
        else $error("port disabled without both lines");

    a_superspeed_follow: assert property (
        @(posedge clk_in) disable iff (srst_in)
        superspeed_disabled_out == port_disabled_out)
        else $error("SuperSpeed disable does not follow port");

    a_fixed_count: assert property (
        @(posedge clk_in) disable iff (srst_in)
        held_q && fixed_lvl_q == `LVL_MED_PD |-> fixed_port_out == `MASK_P12)
        else $error("fixed port mask wrong");

    a_charge_count: assert property (
        @(posedge clk_in) disable iff (srst_in)
        held_q && chg_lvl_q == `LVL_STRONG_PD |-> charging_port_out == `MASK_P1234)
        else $error("charging port mask wrong");

    a_uart_pin_fn: assert property (
        @(posedge clk_in) disable iff (srst_in)
        held_q && function_set_out == `FSET_UART && !pin_override_en_in[4]
        |=> fn_q[4*`FN_WIDTH +: `FN_WIDTH] == `FN_UART_RX)
        else $error("pin 6 not UART receive in set 3");

    a_override_wins: assert property (
        @(posedge clk_in) disable iff (srst_in)
        held_q && pin_override_en_in[4]
        |=> fn_q[4*`FN_WIDTH +: `FN_WIDTH] == $past(pin_override_fn_in[4*`FN_WIDTH +: `FN_WIDTH]))
        else $error("override did not take pin 6");

endmodule

// ---- test/strap_board_model.sv ----
`timescale 1ns/100ps

////////////////////////////////////////////////////////////////////////////////
// Board strap resistors as the bench configures them before each reset.
module strap_board_model (
    // Clock for the floating strap pattern
    input  wire logic       clk_in,
    // Board configuration chosen by the bench
    input  wire logic [3:0] pos_high_in,
    input  wire logic [3:0] neg_high_in,
    input  wire logic [2:0] fixed_level_in,
    input  wire logic [2:0] charging_level_in,
    input  wire logic [1:0] set_sel_in,
    // Strap levels seen by the device
    output logic      [3:0] pos_strap_out,
    output logic      [3:0] neg_strap_out,
    output logic      [2:0] fixed_strap_out,
    output logic      [2:0] charging_strap_out,
    output logic      [2:0] set_lo_strap_out,
    output logic      [2:0] set_hi_strap_out,
    output logic      [2:0] set_unused_strap_out
);
    logic [2:0] float_q = 3'h0;

    assign pos_strap_out = pos_high_in;
    assign neg_strap_out = neg_high_in;
    assign fixed_strap_out = fixed_level_in;
    assign charging_strap_out = charging_level_in;
    assign set_hi_strap_out = 3'h0;
    assign set_lo_strap_out = {1'b0, set_sel_in};

    always_ff @(posedge clk_in) begin
        float_q <= float_q + 3'h3;
    end
    assign set_unused_strap_out = float_q;
endmodule

// ---- test/strap_latch_pin_function_select_bench.sv ----
`timescale 1ns/100ps
`include "strap_cfg.svh"

module strap_latch_pin_function_select_bench;
    logic         clk_in = 1'b0;
    logic         srst_in = 1'b1;
    logic [3:0]   b_pos, b_neg, e_pos, e_neg;
    logic [2:0]   b_fixed, b_chg, e_fixed, e_chg;
    logic [1:0]   b_set, e_set;
    logic [29:0]  ovr_en = '0;
    logic [179:0] ovr_fn = '0;
    logic [3:0]   pos_s, neg_s, pos_o, neg_o, dis_o, ss_o, fix_o, chg_o;
    logic [2:0]   fix_s, chg_s, lo_s, hi_s, un_s;
    logic         rsv_o, valid_o;
    logic [1:0]   set_o;
    logic [179:0] fn_o;
    int           failures = 0;
    int           n_checks = 0;

    initial begin
        forever #4 clk_in = ~clk_in;
    end

    strap_board_model i_board (.clk_in(clk_in), .pos_high_in(b_pos), .neg_high_in(b_neg),
        .fixed_level_in(b_fixed), .charging_level_in(b_chg), .set_sel_in(b_set),
        .pos_strap_out(pos_s), .neg_strap_out(neg_s), .fixed_strap_out(fix_s),
        .charging_strap_out(chg_s), .set_lo_strap_out(lo_s), .set_hi_strap_out(hi_s),
        .set_unused_strap_out(un_s));

    strap_latch_pin_function_select i_dut (.clk_in(clk_in), .srst_in(srst_in),
        .port_pos_line_disable_strap_in(pos_s), .port_neg_line_disable_strap_in(neg_s),
        .fixed_port_count_strap_in(fix_s), .charging_port_count_strap_in(chg_s),
        .function_set_lo_strap_in(lo_s), .function_set_hi_strap_in(hi_s),
        .function_set_unused_strap_in(un_s), .pin_override_en_in(ovr_en),
        .pin_override_fn_in(ovr_fn), .pos_line_disabled_out(pos_o),
        .neg_line_disabled_out(neg_o), .port_disabled_out(dis_o),
        .superspeed_disabled_out(ss_o), .fixed_port_out(fix_o), .charging_port_out(chg_o),
        .strap_reserved_out(rsv_o), .straps_valid_out(valid_o),
        .function_set_out(set_o), .programmable_function_pin_fn_out(fn_o));

    ////////////////////////////////////////////////////////////////////////////
    function automatic logic [3:0] lvl_mask(logic [2:0] l);
        case (l)
            3'h0: return 4'h0;
            3'h1: return 4'h1;
            3'h2: return 4'h3;
            3'h3: return 4'h7;
            3'h4: return 4'hf;
            default: return 4'h0;
        endcase
    endfunction

    function automatic logic [5:0] exp_fn(int pin, logic [1:0] s);
        logic [5:0] v [4];
        v = '{4{`FN_RESERVED}};
        case (pin)
            2: v = '{4{`FN_CABLE_A}};
            3: v = '{4{`FN_CABLE_B}};
            4: v = '{4{`FN_GPIO68}};
            5: v = '{4{`FN_DISCHARGE}};
            6: v = '{`FN_GPIO70, `FN_GPIO70, `FN_UART_RX, `FN_GPIO70};
            7: v = '{`FN_GPIO71, `FN_MICROPHONE_PLUG_DETECT, `FN_UART_TX, `FN_GPIO71};
            8: v = '{4{`FN_PN_DATA}};
            9: v = '{4{`FN_PN_CLOCK}};
            10: v = '{4{`FN_BC_DATA}};
            11: v = '{4{`FN_BC_CLOCK}};
            12: v = '{4{`FN_P3_SS_PWR}};
            13: v = '{4{`FN_P3_PWR}};
            14: v = '{`FN_GPIO78, `FN_I2S_SDI, `FN_UART_CTS_N, `FN_GPIO78};
            15: v = '{4{`FN_ALERT_B}};
            16: v = '{4{`FN_P4_PWR}};
            17: v = '{4{`FN_P1_PWR}};
            18: v = '{4{`FN_ALERT_A}};
            19: v = '{`FN_TGT_DATA, `FN_I2S_SDO, `FN_UART_RTS_N, `FN_GPIO83};
            20: v = '{4{`FN_SPI_CE_N}};
            21: v = '{4{`FN_SPI_CLK}};
            22, 23, 24, 25: v = '{4{`FN_SPI_D0 + 6'(pin - 22)}};
            26: v = '{`FN_TGT_CLOCK, `FN_I2S_SCK, `FN_UART_DSR_N, `FN_GPIO90};
            27: v = '{`FN_GPIO91, `FN_I2S_MCLK, `FN_UART_DTR_N, `FN_GPIO91};
            28: v = '{`FN_GPIO92, `FN_I2S_LRCK, `FN_UART_DCD_N, `FN_GPIO92};
            default: v = '{4{`FN_GPIO93 + 6'(pin - 29)}};
        endcase
        return v[s];
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    task automatic report_and_stop();
        if (failures == 0 && n_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic cmp4(logic [3:0] got, logic [3:0] exp);
        n_checks++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic cmp_fn(logic [5:0] got, logic [5:0] exp);
        n_checks++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Straps are captured on the second edge after release, pin functions one edge later.
    task automatic do_reset();
        srst_in = 1'b1;
        repeat (4) @(posedge clk_in);
        #1;
        cmp4({3'h0, valid_o}, 4'h0);
        srst_in = 1'b0;
        repeat (3) @(posedge clk_in);
        #1;
    endtask

    task automatic check_all(logic rsv);
        cmp4(pos_o, e_pos);
        cmp4(neg_o, e_neg);
        cmp4(dis_o, e_pos & e_neg);
        cmp4(ss_o, e_pos & e_neg);
        cmp4(fix_o, lvl_mask(e_fixed));
        cmp4(chg_o, lvl_mask(e_chg));
        cmp4({3'h0, rsv_o}, {3'h0, rsv});
        cmp4({3'h0, valid_o}, 4'h1);
        cmp4({2'h0, set_o}, {2'h0, e_set});
        for (int i = 0; i < 30; i++) begin
            cmp_fn(fn_o[6*i+:6], exp_fn(i + 2, e_set));
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        #5000;
        failures++;
        report_and_stop();
    end

    initial begin
        for (int k = 0; k < 5; k++) begin
            e_pos = 4'(k * 5 + 3) | {4{k == 4}};
            e_neg = 4'(k * 7 + 6) | {4{k == 4}};
            e_fixed = 3'(k);
            e_chg = 3'(4 - k);
            e_set = 2'(k);
            {b_pos, b_neg, b_fixed, b_chg, b_set} = {e_pos, e_neg, e_fixed, e_chg, e_set};
            do_reset();
            check_all(1'b0);
            // Later strap changes must not disturb the held configuration.
            {b_pos, b_neg, b_fixed, b_chg, b_set} = {~e_pos, ~e_neg, 3'h4 - e_fixed, 3'h2,
                e_set + 2'h1};
            repeat (3) @(posedge clk_in);
            #1;
            check_all(1'b0);
        end
        b_fixed = 3'h5;
        b_chg = 3'h7;
        e_fixed = 3'h5;
        e_chg = 3'h7;
        e_pos = b_pos;
        e_neg = b_neg;
        e_set = b_set;
        do_reset();
        check_all(1'b1);
        ovr_fn[24+:6] = `FN_GPIO83;
        ovr_en[4] = 1'b1;
        @(posedge clk_in);
        #1;
        cmp_fn(fn_o[24+:6], `FN_GPIO83);
        cmp_fn(fn_o[30+:6], exp_fn(7, e_set));
        ovr_en[4] = 1'b0;
        @(posedge clk_in);
        #1;
        cmp_fn(fn_o[24+:6], exp_fn(6, e_set));
        report_and_stop();
    end
endmodule
